// [fsq_regs.svh]
// Register map, field positions, command codes and pin timing of the flash sequencer.
// Assumes a 25 MHz hclk and an AHB-Lite bus with a 32-bit word per register.
`ifndef FSQ_REGS_SVH
`define FSQ_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FSQ_OFF_CMD      8'h00
`define FSQ_OFF_ADDR     8'h04
`define FSQ_OFF_WDATA    8'h08
`define FSQ_OFF_RDATA    8'h0c
`define FSQ_OFF_STATE    8'h10
`define FSQ_OFF_IRQ_ST   8'h14
`define FSQ_OFF_IRQ_MASK 8'h18

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define FSQ_CMD_OP_MSB   3
`define FSQ_CMD_OP_LSB   0
`define FSQ_CMD_ALT_BIT  8
`define FSQ_CMD_AUTO_BIT 9
`define FSQ_OP_LAST      4'h7
`define FSQ_IRQ_DONE     0
`define FSQ_IRQ_ERR      1
`define FSQ_IRQ_REFUSE   2
`define FSQ_SR_READY     7
`define FSQ_SR_ESEQ      5
`define FSQ_SR_EPROG     4
`define FSQ_SR_EVPP      3
`define FSQ_SR_SUSP      2
`define FSQ_SR_ELOCK     1
`define FSQ_SR_ERR_MASK  8'h3a

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define FSQ_CODE_RDSR      8'h70
`define FSQ_CODE_PSETUP    8'h40
`define FSQ_CODE_PSETUP2   8'h10
`define FSQ_CODE_SUSPEND   8'hb0
`define FSQ_CODE_RESUME    8'hd0
`define FSQ_CODE_RDARR     8'hff
`define FSQ_CODE_LSETUP    8'h60
`define FSQ_CODE_LBLOCK    8'h01
`define FSQ_CODE_LPERM     8'hf1
`define FSQ_CODE_CLRSR     8'h50

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FSQ_CLK_NS       40
`define FSQ_T_STB_NS     100
`define FSQ_STB_CYC      ((`FSQ_T_STB_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS)

`endif

// [fsq_pkg.sv]
// Types shared by the flash sequencer.
// Assumes fsq_regs.svh for the numeric encodings.
package fsq_pkg;
  typedef enum logic [3:0] {
    FSQ_OP_RDSR   = 4'h0,
    FSQ_OP_PROG   = 4'h1,
    FSQ_OP_SUSP   = 4'h2,
    FSQ_OP_RESUME = 4'h3,
    FSQ_OP_RDARR  = 4'h4,
    FSQ_OP_LOCKB  = 4'h5,
    FSQ_OP_LOCKP  = 4'h6,
    FSQ_OP_CLRSR  = 4'h7
  } fsq_op_t;
  typedef enum logic [1:0] {B_IDLE, B_SET, B_STB, B_REC} fsq_bus_t;
  typedef enum logic [2:0] {S_IDLE, S_CMD1, S_CMD2, S_POLL, S_READ, S_FFH} fsq_seq_t;
endpackage : fsq_pkg

// [fsq_ctrl.sv]
// Host-side controller that sequences program, suspend, resume and lock commands
// onto an asynchronous flash bus, with an AHB-Lite slave register file.
// Assumes one clock, flash pins timed off hclk, and software polling or irq.
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fsq_regs.svh"

module fsq_ctrl
  import fsq_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  output logic [19:0]      flash_addr,
  output logic [15:0]      flash_wdq,
  input  wire logic [15:0] flash_rdq,
  output logic             flash_dq_oe_n,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n
);

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------
  // Zero wait states; reads are muxed in the address phase so hrdata is a flop.
  logic        wr_pend_q;
  logic [7:0]  wr_off_q;
  logic [31:0] hrdata_q;
  logic [19:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [7:0]  last_sr_q;
  logic [7:0]  err_acc_q;
  logic        err_lock_q;
  logic        susp_q;
  logic [19:0] prog_addr_q;
  logic [2:0]  irq_st_q;
  logic [2:0]  irq_mask_q;
  logic        irq_q;
  fsq_op_t     op_q;
  logic        alt_q;
  logic        auto_q;
  fsq_seq_t    sst_q;
  logic        issued_q;

  wire         ahb_take = hsel & htrans[1] & hready;
  wire         ahb_rd   = ahb_take & ~hwrite;
  wire         ahb_wr   = ahb_take & hwrite;
  wire [7:0]   a_off    = haddr[7:0];
  wire         busy     = (sst_q != S_IDLE);
  wire         irq_rdclr = ahb_rd & (a_off == `FSQ_OFF_IRQ_ST);
  wire         wr_cmd   = wr_pend_q & (wr_off_q == `FSQ_OFF_CMD);
  wire         wr_addr  = wr_pend_q & (wr_off_q == `FSQ_OFF_ADDR);
  wire         wr_wdata = wr_pend_q & (wr_off_q == `FSQ_OFF_WDATA);
  wire         wr_mask  = wr_pend_q & (wr_off_q == `FSQ_OFF_IRQ_MASK);
  wire [31:0]  state_word = {8'h00, err_acc_q, last_sr_q, 5'h00, err_lock_q, susp_q, busy};
  wire [31:0]  rd_mux =
    (a_off == `FSQ_OFF_CMD)      ? {22'h000000, auto_q, alt_q, 4'h0, op_q} :
    (a_off == `FSQ_OFF_ADDR)     ? {12'h000, addr_q} :
    (a_off == `FSQ_OFF_WDATA)    ? {16'h0000, wdata_q} :
    (a_off == `FSQ_OFF_RDATA)    ? {16'h0000, rdata_q} :
    (a_off == `FSQ_OFF_STATE)    ? state_word :
    (a_off == `FSQ_OFF_IRQ_ST)   ? {29'h00000000, irq_st_q} :
    (a_off == `FSQ_OFF_IRQ_MASK) ? {29'h00000000, irq_mask_q} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_off_q  <= 8'h00;
      hrdata_q  <= 32'h00000000;
    end else begin
      wr_pend_q <= ahb_wr;
      if (ahb_take) begin
        wr_off_q <= a_off;
      end
      if (ahb_rd) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // --------------------------------------------------------------------------
  // Command decode and refusal
  // --------------------------------------------------------------------------
  wire [3:0] new_raw = hwdata[`FSQ_CMD_OP_MSB:`FSQ_CMD_OP_LSB];
  wire fsq_op_t new_op = fsq_op_t'(new_raw);
  wire new_legal  = (new_raw <= `FSQ_OP_LAST);
  wire new_modify = (new_op == FSQ_OP_PROG) | (new_op == FSQ_OP_LOCKB) | (new_op == FSQ_OP_LOCKP);
  wire refuse_err = new_modify & err_lock_q;
  wire refuse_rd  = (new_op == FSQ_OP_RDARR) & susp_q & (addr_q == prog_addr_q);
  wire refuse_seq = ((new_op == FSQ_OP_RESUME) & ~susp_q) | ((new_op == FSQ_OP_PROG) & susp_q);
  // Busy refusal means each location waits for ready before its next setup
  wire refuse     = wr_cmd & (busy | ~new_legal | refuse_err | refuse_rd | refuse_seq);
  wire start      = wr_cmd & ~refuse;

  // --------------------------------------------------------------------------
  // Flash pin engine
  // --------------------------------------------------------------------------
  // One access is set, strobe for the access time, then a recovery cycle.
  fsq_bus_t    bst_q;
  logic [1:0]  bcnt_q;
  logic        bwr_q;
  logic [15:0] brd_q;
  logic [19:0] faddr_q;
  logic [15:0] fdq_q;
  logic        foe_dq_n_q;
  logic        fce_n_q;
  logic        foe_n_q;
  logic        fwe_n_q;
  logic        bus_wr;
  logic [15:0] bus_d;
  wire         bus_done = (bst_q == B_REC);
  wire         bus_go   = busy & ~issued_q & (bst_q == B_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bst_q      <= B_IDLE;
      bcnt_q     <= 2'h0;
      bwr_q      <= 1'b0;
      brd_q      <= 16'h0000;
      faddr_q    <= 20'h00000;
      fdq_q      <= 16'h0000;
      foe_dq_n_q <= 1'b1;
      fce_n_q    <= 1'b1;
      foe_n_q    <= 1'b1;
      fwe_n_q    <= 1'b1;
    end else begin
      unique case (bst_q)
        B_IDLE: if (bus_go) begin
          faddr_q    <= addr_q;
          fdq_q      <= bus_d;
          foe_dq_n_q <= ~bus_wr;
          fce_n_q    <= 1'b0;
          bwr_q      <= bus_wr;
          bst_q      <= B_SET;
        end
        B_SET: begin
          fwe_n_q <= ~bwr_q;
          foe_n_q <= bwr_q;
          bcnt_q  <= 2'(`FSQ_STB_CYC - 1);
          bst_q   <= B_STB;
        end
        B_STB: if (bcnt_q == 2'h0) begin
          fwe_n_q <= 1'b1;
          foe_n_q <= 1'b1;
          brd_q   <= flash_rdq;
          bst_q   <= B_REC;
        end else begin
          bcnt_q <= bcnt_q - 2'h1;
        end
        B_REC: begin
          fce_n_q    <= 1'b1;
          foe_dq_n_q <= 1'b1;
          bst_q      <= B_IDLE;
        end
      endcase
    end
  end

  assign flash_addr    = faddr_q;
  assign flash_wdq     = fdq_q;
  assign flash_dq_oe_n = foe_dq_n_q;
  assign flash_ce_n    = fce_n_q;
  assign flash_oe_n    = foe_n_q;
  assign flash_we_n    = fwe_n_q;

  // --------------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------------
  wire has2  = (op_q == FSQ_OP_PROG) | (op_q == FSQ_OP_LOCKB) | (op_q == FSQ_OP_LOCKP);
  wire hasrd = (op_q == FSQ_OP_RDSR) | (op_q == FSQ_OP_RDARR);
  wire nopoll = hasrd | (op_q == FSQ_OP_CLRSR);
  wire [7:0] code1 =
    (op_q == FSQ_OP_RDSR)   ? `FSQ_CODE_RDSR :
    (op_q == FSQ_OP_PROG)   ? (alt_q ? `FSQ_CODE_PSETUP2 : `FSQ_CODE_PSETUP) :
    (op_q == FSQ_OP_SUSP)   ? `FSQ_CODE_SUSPEND :
    (op_q == FSQ_OP_RESUME) ? `FSQ_CODE_RESUME :
    (op_q == FSQ_OP_RDARR)  ? `FSQ_CODE_RDARR :
    (op_q == FSQ_OP_CLRSR)  ? `FSQ_CODE_CLRSR : `FSQ_CODE_LSETUP;
  wire [7:0] code2 = (op_q == FSQ_OP_LOCKP) ? `FSQ_CODE_LPERM : `FSQ_CODE_LBLOCK;
  wire ready_seen = bus_done & brd_q[`FSQ_SR_READY];
  wire [7:0] sr_err = brd_q[7:0] & `FSQ_SR_ERR_MASK;
  wire capture = ((sst_q == S_POLL) & ready_seen) | ((sst_q == S_READ) & bus_done & (op_q == FSQ_OP_RDSR));
  wire op_end = bus_done & (((sst_q == S_CMD1) & ~has2 & nopoll & ~hasrd) | (sst_q == S_READ)
                | (sst_q == S_FFH) | ((sst_q == S_POLL) & ready_seen & ~(auto_q & has2)));
  wire clr_done = op_end & (op_q == FSQ_OP_CLRSR);

  assign bus_wr = (sst_q != S_POLL) & (sst_q != S_READ);
  assign bus_d  = (sst_q == S_CMD2) ? ((op_q == FSQ_OP_PROG) ? wdata_q : {8'h00, code2}) :
                  (sst_q == S_FFH)  ? {8'h00, `FSQ_CODE_RDARR} : {8'h00, code1};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sst_q    <= S_IDLE;
      issued_q <= 1'b0;
      op_q     <= FSQ_OP_RDSR;
      alt_q    <= 1'b0;
      auto_q   <= 1'b0;
    end else begin
      if (bus_go) begin
        issued_q <= 1'b1;
      end else if (bus_done) begin
        issued_q <= 1'b0;
      end
      unique case (sst_q)
        S_IDLE: if (start) begin
          op_q   <= new_op;
          alt_q  <= hwdata[`FSQ_CMD_ALT_BIT];
          auto_q <= hwdata[`FSQ_CMD_AUTO_BIT];
          sst_q  <= S_CMD1;
        end
        S_CMD1: if (bus_done) begin
          sst_q <= has2 ? S_CMD2 : hasrd ? S_READ : nopoll ? S_IDLE : S_POLL;
        end
        S_CMD2: if (bus_done) begin
          sst_q <= S_POLL;
        end
        // Not ready means keep polling; software decides on any overall timeout
        S_POLL: if (ready_seen) begin
          sst_q <= (auto_q & has2) ? S_FFH : S_IDLE;
        end
        S_READ: if (bus_done) begin
          sst_q <= S_IDLE;
        end
        S_FFH: if (bus_done) begin
          sst_q <= S_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Status tracking
  // --------------------------------------------------------------------------
  // Errors OR in across a series so one check at the end catches them all
  wire [7:0] err_acc_d = clr_done ? 8'h00 : (err_acc_q | (capture ? sr_err : 8'h00));
  wire [2:0] irq_ev = {refuse, capture & (sr_err != 8'h00), op_end};
  wire [2:0] irq_st_d = (irq_st_q & (irq_rdclr ? 3'h0 : 3'h7)) | irq_ev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q      <= 20'h00000;
      wdata_q     <= 16'h0000;
      rdata_q     <= 16'h0000;
      last_sr_q   <= 8'h00;
      err_acc_q   <= 8'h00;
      err_lock_q  <= 1'b0;
      susp_q      <= 1'b0;
      prog_addr_q <= 20'h00000;
      irq_st_q    <= 3'h0;
      irq_mask_q  <= 3'h0;
      irq_q       <= 1'b0;
    end else begin
      if (wr_addr) begin
        addr_q <= hwdata[19:0];
      end
      if (wr_wdata) begin
        wdata_q <= hwdata[15:0];
      end
      if (wr_mask) begin
        irq_mask_q <= hwdata[2:0];
      end
      if (capture) begin
        last_sr_q <= brd_q[7:0];
      end
      if ((sst_q == S_READ) & bus_done) begin
        rdata_q <= brd_q;
      end
      err_acc_q  <= err_acc_d;
      err_lock_q <= (err_acc_d != 8'h00);
      if (start & (new_op == FSQ_OP_PROG)) begin
        prog_addr_q <= addr_q;
      end
      if (start & (new_op == FSQ_OP_RESUME)) begin
        susp_q <= 1'b0;
      end else if ((sst_q == S_POLL) & ready_seen & (op_q == FSQ_OP_SUSP)) begin
        susp_q <= brd_q[`FSQ_SR_SUSP];
      end
      irq_st_q <= irq_st_d;
      irq_q    <= (irq_st_d & irq_mask_q) != 3'h0;
    end
  end
  assign irq = irq_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking fsq_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_poll_until_ready: assert property (
    (sst_q == S_POLL) && bus_done && !brd_q[7] |=> (sst_q == S_POLL))
    else $error("poll left before ready");
  a_prog_setup_code: assert property (
    bus_go && (sst_q == S_CMD1) && (op_q == FSQ_OP_PROG) |->
      (bus_d == 16'h0040) || (bus_d == 16'h0010))
    else $error("bad program setup code");
  a_prog_data_word: assert property (
    bus_go && (sst_q == S_CMD2) && (op_q == FSQ_OP_PROG) |=>
      (flash_wdq == wdata_q) && (flash_addr == addr_q) && !flash_dq_oe_n)
    else $error("program data not driven at target");
  a_we_pulse_width: assert property (
    $fell(flash_we_n) |-> (!flash_we_n)[*3] ##1 flash_we_n)
    else $error("write strobe width wrong");
  a_err_sticky: assert property (
    !clr_done |=> (err_acc_q & $past(err_acc_q)) == $past(err_acc_q))
    else $error("error flag lost without clear");
  a_err_accum: assert property (
    capture && !clr_done |=> (err_acc_q & $past(sr_err)) == $past(sr_err))
    else $error("captured error not accumulated");
  a_err_blocks: assert property (
    wr_cmd && !busy && err_lock_q && new_modify |=> (sst_q == S_IDLE) && irq_st_q[2])
    else $error("modify started with error pending");
  a_ffh_follows: assert property (
    (sst_q == S_POLL) && ready_seen && auto_q && has2 |=> (sst_q == S_FFH)
      && bus_go && (bus_d == 16'h00ff))
    else $error("read-array not issued after operation");
  a_susp_state: assert property (
    (sst_q == S_POLL) && ready_seen && (op_q == FSQ_OP_SUSP) |=> susp_q == $past(brd_q[2]))
    else $error("suspend flag mismatch");
  a_rd_guard: assert property (
    wr_cmd && (new_op == FSQ_OP_RDARR) && susp_q && (addr_q == prog_addr_q) |=> !busy)
    else $error("read of suspended location issued");
  a_lock_confirm: assert property (
    bus_go && (sst_q == S_CMD2) && (op_q != FSQ_OP_PROG) |->
      bus_d == ((op_q == FSQ_OP_LOCKP) ? 16'h00f1 : 16'h0001))
    else $error("bad lock confirm code");
  a_no_contention: assert property (
    !flash_dq_oe_n |-> flash_oe_n)
    else $error("data driven while output enabled");
  c_prog_done: cover property (op_end && (op_q == FSQ_OP_PROG));
  c_suspended: cover property ((sst_q == S_POLL) && ready_seen && (op_q == FSQ_OP_SUSP) && brd_q[2]);
  c_lock_perm: cover property (op_end && (op_q == FSQ_OP_LOCKP));
  c_err_seen:  cover property (capture && (sr_err != 8'h00));

endmodule : fsq_ctrl

// [fsq_flash_model.sv]
// Behavioural flash device on the far side of the sequencer's pins.
// Assumes writes end on the rising edge of we_n with ce_n low; reads use oe_n.
`timescale 1ns/1ps
module fsq_flash_model #(
  parameter int BUSY_CYC = 6
) (
  input  wire logic        hclk,
  input  wire logic [19:0] flash_addr,
  input  wire logic [15:0] flash_wdq,
  input  wire logic        flash_dq_oe_n,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  output logic [15:0]      flash_rdq
);
  // ---------------------------------------------------------------------------
  // Device state
  // ---------------------------------------------------------------------------
  logic [15:0] mem [0:4095];
  int          busy_cnt    = 0;
  logic        susp        = 1'b0;
  logic        status_mode = 1'b0;
  logic        vpp_bad     = 1'b0;
  logic        prog_fail   = 1'b0;
  logic        perm        = 1'b0;
  logic [31:0] blk_lock    = 32'h0;
  logic [7:0]  err         = 8'h00;
  logic [7:0]  pend        = 8'h00;
  logic [7:0]  code        = 8'h00;
  logic [7:0]  last_setup  = 8'h00;
  logic [15:0] last_q      = 16'h0;
  wire         drive       = !flash_ce_n && !flash_oe_n;
  wire  [7:0]  status      = {busy_cnt == 0 || susp, 1'b0, err[5:3], susp, err[1], 1'b0};
  // Released bus shows the inverse of the last word, so a stale sample is caught
  assign flash_rdq = drive ? (status_mode ? {8'h00, status} : mem[flash_addr[11:0]]) : ~last_q;
  always @(posedge hclk) begin
    if (drive) last_q <= flash_rdq;
    if (busy_cnt > 0 && !susp) busy_cnt <= busy_cnt - 1;
  end
  // ---------------------------------------------------------------------------
  // Command decoder
  // ---------------------------------------------------------------------------
  always @(posedge flash_we_n) if (!flash_ce_n) begin
    code        = flash_wdq[7:0];
    status_mode = 1'b1;
    if (pend inside {8'h40, 8'h10}) begin
      last_setup = pend;
      if (vpp_bad) err[3] = 1'b1;
      else if (blk_lock[flash_addr[19:15]]) err[1] = 1'b1;
      else if (prog_fail) err[4] = 1'b1;
      else mem[flash_addr[11:0]] = flash_wdq;
      busy_cnt = BUSY_CYC;
    end else if (pend == 8'h60) begin
      if (code == 8'h01 && perm) err[1] = 1'b1;
      else if (code == 8'h01) blk_lock[flash_addr[19:15]] = 1'b1;
      else if (code == 8'hf1) perm = 1'b1;
      else err[5:4] = 2'b11;
      busy_cnt = BUSY_CYC;
    end else case (code)
      8'hff: status_mode = 1'b0;
      8'h50: err = 8'h00;
      8'hb0: susp = busy_cnt > 0;
      8'hd0: susp = 1'b0;
      default: ;
    endcase
    pend = (pend == 8'h00 && code inside {8'h40, 8'h10, 8'h60}) ? code : 8'h00;
  end
endmodule : fsq_flash_model

// [fsq_ctrl_bench.sv]
// Self-checking bench for the flash sequencer, driven over AHB-Lite.
// Assumes fsq_flash_model on the pins and hready tied to hreadyout.
`timescale 1ns/1ps
`include "fsq_regs.svh"
module fsq_ctrl_bench
  import fsq_pkg::*;
();
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [19:0] flash_addr;
  logic [15:0] flash_wdq, flash_rdq;
  logic        flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n;
  int          miscompares = 0;
  int          check_count = 0;
  assign hready = hreadyout;
  fsq_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .flash_addr(flash_addr), .flash_wdq(flash_wdq), .flash_rdq(flash_rdq),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n));
  fsq_flash_model #(.BUSY_CYC(6)) i_flash (.hclk(hclk), .flash_addr(flash_addr),
    .flash_wdq(flash_wdq), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_rdq(flash_rdq));
  // ---------------------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Every wait after the first edge past reset goes through here, so a hang always ends in the report
  task automatic tick(inout int n);
    @(posedge hclk);
    n++;
    if (n > 3000) begin
      miscompares++;
      test_done();
    end
  endtask : tick
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    tick(n);
    while (hready !== 1'b1) tick(n);
    htrans <= 2'b00;
    hwdata <= wd;
    tick(n);
    while (hready !== 1'b1) tick(n);
    rd = hrdata;
  endtask : ahb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, v);
    chk(nm, e, v);
  endtask : rd_chk
  // Loads address and data, starts the command, then polls busy until it drops
  task automatic run(input logic [31:0] c, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    ahb(1'b1, `FSQ_OFF_ADDR, {12'h0, a}, v);
    ahb(1'b1, `FSQ_OFF_WDATA, {16'h0, d}, v);
    ahb(1'b1, `FSQ_OFF_CMD, c, v);
    v = 32'h1;
    while (v[0] !== 1'b0) begin
      ahb(1'b0, `FSQ_OFF_STATE, 32'h0, v);
      tick(n);
    end
  endtask : run
  task automatic refused(input logic [31:0] c, input logic [19:0] a);
    ahb(1'b0, `FSQ_OFF_IRQ_ST, 32'h0, v);
    run(c, a, 16'h0);
    rd_chk("irq refused", `FSQ_OFF_IRQ_ST, 32'h4);
  endtask : refused
  task automatic fresh();
    run(32'(FSQ_OP_CLRSR), 20'h0, 16'h0);
    run(32'(FSQ_OP_RDSR), 20'h0, 16'h0);
    rd_chk("status clean", `FSQ_OFF_RDATA, 32'h80);
  endtask : fresh
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("idle strobes", 4'hf, {flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe_n});
    chk("bus response", 32'h2, {hreadyout, hresp});
    rd_chk("mask reset", `FSQ_OFF_IRQ_MASK, 32'h0);
    ahb(1'b1, 8'h1c, 32'hffffffff, v);
    rd_chk("unmapped", 8'h1c, 32'h0);
    ahb(1'b1, `FSQ_OFF_IRQ_MASK, 32'h7, v);
    $display("test reset done");
    run(32'(FSQ_OP_RDSR), 20'h0, 16'h0);
    rd_chk("status read", `FSQ_OFF_RDATA, 32'h80);
    chk("irq done", 1'b1, irq);
    rd_chk("irq status", `FSQ_OFF_IRQ_ST, 32'h1);
    rd_chk("irq cleared", `FSQ_OFF_IRQ_ST, 32'h0);
    chk("irq low", 1'b0, irq);
    run(32'(FSQ_OP_PROG), 20'h00100, 16'h1234);
    chk("setup 40", 8'h40, i_flash.last_setup);
    rd_chk("prog state", `FSQ_OFF_STATE, 32'h00008000);
    run(32'h301, 20'h00102, 16'habcd);
    chk("setup 10", 8'h10, i_flash.last_setup);
    chk("array mode", 1'b0, i_flash.status_mode);
    run(32'(FSQ_OP_RDARR), 20'h00100, 16'h0);
    rd_chk("array word", `FSQ_OFF_RDATA, 32'h1234);
    $display("test program done");
    i_flash.vpp_bad = 1'b1;
    run(32'(FSQ_OP_PROG), 20'h00200, 16'h5555);
    i_flash.vpp_bad = 1'b0;
    rd_chk("supply error", `FSQ_OFF_STATE, 32'h00088804);
    rd_chk("irq error", `FSQ_OFF_IRQ_ST, 32'h3);
    run(32'(FSQ_OP_RDSR), 20'h0, 16'h0);
    rd_chk("sticky error", `FSQ_OFF_STATE, 32'h00088804);
    refused(32'(FSQ_OP_PROG), 20'h00200);
    fresh();
    i_flash.prog_fail = 1'b1;
    run(32'(FSQ_OP_PROG), 20'h00204, 16'h5555);
    i_flash.prog_fail = 1'b0;
    rd_chk("write error", `FSQ_OFF_STATE, 32'h00109004);
    fresh();
    // Arm a pending lock setup so the clear code lands as a bad confirm
    i_flash.pend = 8'h60;
    run(32'(FSQ_OP_CLRSR), 20'h0, 16'h0);
    run(32'(FSQ_OP_RDSR), 20'h0, 16'h0);
    rd_chk("sequence error", `FSQ_OFF_STATE, 32'h0030b004);
    fresh();
    $display("test errors done");
    run(32'(FSQ_OP_LOCKB), 20'h08000, 16'h0);
    chk("block locked", 1'b1, i_flash.blk_lock[1]);
    rd_chk("lock state", `FSQ_OFF_STATE, 32'h00008000);
    run(32'(FSQ_OP_PROG), 20'h08004, 16'h0001);
    rd_chk("protect error", `FSQ_OFF_STATE, 32'h00028204);
    fresh();
    run(32'(FSQ_OP_LOCKP), 20'h00000, 16'h0);
    chk("perm locked", 1'b1, i_flash.perm);
    run(32'(FSQ_OP_LOCKB), 20'h10000, 16'h0);
    rd_chk("perm protect", `FSQ_OFF_STATE, 32'h00028204);
    fresh();
    $display("test lock done");
    run(32'(FSQ_OP_PROG), 20'h00300, 16'h7777);
    // Stretch the device's algorithm so the suspend lands mid-program
    i_flash.busy_cnt = 300;
    run(32'(FSQ_OP_SUSP), 20'h0, 16'h0);
    rd_chk("suspended", `FSQ_OFF_STATE, 32'h00008402);
    refused(32'(FSQ_OP_RDARR), 20'h00300);
    refused(32'(FSQ_OP_PROG), 20'h00310);
    run(32'(FSQ_OP_RDARR), 20'h00102, 16'h0);
    rd_chk("suspend read", `FSQ_OFF_RDATA, 32'habcd);
    run(32'(FSQ_OP_RESUME), 20'h0, 16'h0);
    rd_chk("resumed", `FSQ_OFF_STATE, 32'h00008000);
    chk("algo finished", 0, i_flash.busy_cnt);
    run(32'(FSQ_OP_SUSP), 20'h0, 16'h0);
    rd_chk("completed", `FSQ_OFF_STATE, 32'h00008000);
    refused(32'(FSQ_OP_RESUME), 20'h0);
    refused(32'h8, 20'h0);
    $display("test suspend done");
    ahb(1'b1, `FSQ_OFF_IRQ_MASK, 32'h0, v);
    run(32'(FSQ_OP_RDSR), 20'h0, 16'h0);
    chk("irq masked", 1'b0, irq);
    ahb(1'b1, `FSQ_OFF_IRQ_MASK, 32'h1, v);
    rd_chk("mask value", `FSQ_OFF_IRQ_MASK, 32'h1);
    chk("irq unmasked", 1'b1, irq);
    $display("test irq done");
    test_done();
  end
endmodule : fsq_ctrl_bench
